// ===== isag_defines.vh
// Constants for the interrupt aggregator: offsets, bit positions, counts
// Behaviour
// [R01] One active-low interrupt output flags every special event to the host; the code never flags the D change bit.
// [R02] Top status bits 5-0 point at D, D-ext, A, A-ext, B, B-ext registers.
// [R03] Auxiliary pin six and seven events appear directly in top bits 6, 7.
// [R04] Host reads top status first to find the lower registers at fault.
// [R05] Interrupt stays low until every pending source is cleared by reading; the code clears aux bits 7, 6 by a write to the aux clear register.
// [R06] Host may write all ones then old value to top mask for edge.
// [R07] A set top mask bit stops that top status bit from interrupting.
// [R08] Top status is live OR of lower registers; acknowledging clears pointer.
// [R09] Each B-channel status bit has its own mask bit per channel.
// [R10] Pool-full fires once 64 bytes of an unfinished message are stored.
// [R11] Message-end fires when a whole message or its last part is stored.
// [R12] Frame-overflow fires when FIFO is full and a new frame starts.
// [R13] Frame-start fires only if enabled, two bytes after frame recognition.
// [R14] At frame-start, header, address low one and status 3-0 are valid.
// [R15] D status read clears all but change bit; CI read clears that.
// [R16] Reading D extended register clears it and its top pointer bit.
// [R17] Masked D status bits hide on read and stay pending until unmasked.
// [R18] Interrupt is OR of all unmasked pending sources, evaluated every clock; the code leaves out the D change bit.
`ifndef ISAG_DEFINES_VH
`define ISAG_DEFINES_VH
`define ISAG_OFS_TOP     6'h00
`define ISAG_OFS_TMASK   6'h01
`define ISAG_OFS_DSTAT   6'h02
`define ISAG_OFS_DEXT    6'h03
`define ISAG_OFS_DMASK   6'h04
`define ISAG_OFS_CIR     6'h05
`define ISAG_OFS_CFG2    6'h06
`define ISAG_OFS_AUXCLR  6'h07
`define ISAG_OFS_BSTAT   6'h08
`define ISAG_OFS_BEXT    6'h09
`define ISAG_OFS_BMASK   6'h0A
`define ISAG_OFS_BHDR    6'h0B
`define ISAG_OFS_BRAL    6'h0C
`define ISAG_OFS_BRST    6'h0D
`define ISAG_CH_STRIDE   6'h08
`define ISAG_TOP_EXB     0
`define ISAG_TOP_ICB     1
`define ISAG_TOP_EXA     2
`define ISAG_TOP_ICA     3
`define ISAG_TOP_EXD     4
`define ISAG_TOP_IDC     5
`define ISAG_TOP_AUX_PIN_SIX    6
`define ISAG_TOP_AUX_PIN_SEVEN    7
`define ISAG_B_RME       7
`define ISAG_B_RPF       6
`define ISAG_BX_RFO      3
`define ISAG_BX_RFS      2
`define ISAG_D_CIC       2
`define ISAG_MASK_RST    8'h00
`define ISAG_POOL_BYTES  7'h40
`define ISAG_RFS_DELAY   2'h2
`endif

// ===== isag_host.sv
// Host processor model: single-word AHB-Lite master
`timescale 1ns/1ns
module isag_host (
  input  wire         hclk,   // Clock
  input  wire         hready, // Bus ready
  input  wire  [31:0] hrdata, // Read data
  output logic        hsel,   // Select
  output logic [31:0] haddr,  // Address
  output logic [1:0]  htrans, // Transfer type
  output logic        hwrite, // Write
  output logic [2:0]  hsize,  // Transfer size
  output logic [31:0] hwdata  // Write data
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
  end
  // Entered just after a rising edge; returns at the edge ending the data
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
endmodule // isag_host

// ===== isag_top.v
// Interrupt aggregator with AHB-Lite register slave and B receive events
`timescale 1ns/1ns
`include "isag_defines.vh"
module isag_top (
  input  wire        hclk,          // System clock
  input  wire        hresetn,       // Async reset, active low
  input  wire        hsel,          // Slave select
  input  wire [31:0] haddr,         // Byte address
  input  wire [1:0]  htrans,        // Transfer type
  input  wire        hwrite,        // Write when high
  input  wire [2:0]  hsize,         // Transfer size
  input  wire [31:0] hwdata,        // Write data
  input  wire        hready,        // Bus ready in
  output reg  [31:0] hrdata,        // Read data
  output reg         hreadyout,     // Slave ready
  output reg         hresp,         // Response, always OKAY
  input  wire [1:0]  rx_byte_stb,   // Byte stored in receive FIFO, per ch
  input  wire [1:0]  rx_msg_done,   // CRC and closing flag received
  input  wire [1:0]  rx_frame_seen, // Address check ok or opening flag
  input  wire [1:0]  rx_fifo_full,  // Receive FIFO full level
  input  wire [15:0] rx_hdr_in,     // Header control byte, ch B high
  input  wire [15:0] rx_rx_address_low_one_in,    // Address low one byte, ch B high
  input  wire [7:0]  rx_stat_in,    // Frame status 3-0, ch B high
  input  wire [11:0] bch_evt_in,    // Other B status events 5-0
  input  wire [11:0] bch_ext_in,    // Other B ext events 7-4,1-0
  input  wire [7:0]  dch_evt_in,    // D status event pulses
  input  wire [7:0]  dch_ext_in,    // D extended event pulses
  input  wire        ci_chg_stb,    // New command/indicate code
  input  wire [3:0]  ci_code_in,    // Command/indicate code
  input  wire        aux_pin_six_pin,      // Auxiliary pin six, async
  input  wire        aux_pin_seven_pin,      // Auxiliary pin seven, async
  output reg         int_n          // Interrupt request, active low
);

  function [7:0] set_clr;
    input [7:0] cur;
    input [7:0] clr;
    input [7:0] set;
    begin
      set_clr = (cur & ~clr) | set;
    end
  endfunction

  // Software registers
  reg [7:0] tmask_q;
  reg [7:0] dstat_q;
  reg [7:0] dext_q;
  reg [7:0] dmask_q;
  reg [3:0] ci_q;
  reg [1:0] cfg2_q;
  reg [1:0] aux_q;
  reg [7:0] bstat_q [0:1];
  reg [7:0] bext_q  [0:1];
  reg [7:0] bmask_q [0:1];
  reg [7:0] bhdr_q  [0:1];
  reg [7:0] bral_q  [0:1];
  reg [3:0] brst_q  [0:1];
  // Receive event sequencing
  reg [6:0] cnt_q   [0:1];
  reg [1:0] dly_q   [0:1];
  reg [1:0] arm_q;
  // Bus data phase
  reg       wr_q;
  reg [5:0] wa_q;
  // Aux pin synchronisers
  reg [1:0] s1_q;
  reg [1:0] s2_q;
  reg [1:0] s3_q;
  reg [1:0] stab_q;

  wire       acc  = hsel & hready & htrans[1];
  wire       rd   = acc & ~hwrite;
  wire [5:0] ra   = haddr[7:2];
  wire [5:0] rb   = ra - `ISAG_CH_STRIDE;
  wire       wlo  = wr_q;
  wire [7:0] wd   = hwdata[7:0];

  // Live top status built from the lower registers and the aux event bits
  wire       dchan_pointer_bit  = |(dstat_q & ~dmask_q & ~(8'h01 << `ISAG_D_CIC));
  wire [7:0] top  = {aux_q[1], aux_q[0], dchan_pointer_bit, |dext_q,
                     |(bstat_q[0] & ~bmask_q[0]), |bext_q[0],
                     |(bstat_q[1] & ~bmask_q[1]), |bext_q[1]}; // [R02] [R03] [R08]

  // Aux events on a settled falling edge
  wire [1:0] aux_fall = stab_q & ~s2_q & ~s3_q;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q   <= 2'h3;
      s2_q   <= 2'h3;
      s3_q   <= 2'h3;
      stab_q <= 2'h3;
    end else begin
      s1_q <= {aux_pin_seven_pin, aux_pin_six_pin};
      s2_q <= s1_q;
      s3_q <= s2_q;
      stab_q <= (s2_q & s3_q) | (stab_q & (s2_q | s3_q));
    end
  end

  // Bus front end: read data registered from the address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_q      <= 1'b0;
      wa_q      <= 6'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_q      <= acc & hwrite;
      if (acc)
        wa_q <= ra;
      if (rd) begin
        hrdata <= 32'h0000_0000;
        case (ra)
          `ISAG_OFS_TOP:   hrdata[7:0] <= top;
          `ISAG_OFS_TMASK: hrdata[7:0] <= tmask_q;
          `ISAG_OFS_DSTAT: hrdata[7:0] <= dstat_q & ~dmask_q; // [R17]
          `ISAG_OFS_DEXT:  hrdata[7:0] <= dext_q;
          `ISAG_OFS_DMASK: hrdata[7:0] <= dmask_q;
          `ISAG_OFS_CIR:   hrdata[3:0] <= ci_q;
          `ISAG_OFS_CFG2:  hrdata[1:0] <= cfg2_q;
          default: begin
            if (ra >= `ISAG_OFS_BSTAT && rb[5:4] == 2'h0 &&
                rb[2:0] <= 3'h5) begin
              case (rb[2:0])
                3'h0:    hrdata[7:0] <= bstat_q[rb[3]];
                3'h1:    hrdata[7:0] <= bext_q[rb[3]];
                3'h2:    hrdata[7:0] <= bmask_q[rb[3]];
                3'h3:    hrdata[7:0] <= bhdr_q[rb[3]];
                3'h4:    hrdata[7:0] <= bral_q[rb[3]];
                default: hrdata[3:0] <= brst_q[rb[3]];
              endcase
            end
          end
        endcase
      end
    end
  end

  // Top, D-channel and aux registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmask_q <= `ISAG_MASK_RST;
      dmask_q <= `ISAG_MASK_RST;
      dstat_q <= 8'h00;
      dext_q  <= 8'h00;
      ci_q    <= 4'h0;
      cfg2_q  <= 2'h0;
      aux_q   <= 2'h0;
    end else begin
      if (wlo && wa_q == `ISAG_OFS_TMASK)
        tmask_q <= wd; // [R07]
      if (wlo && wa_q == `ISAG_OFS_DMASK)
        dmask_q <= wd;
      if (wlo && wa_q == `ISAG_OFS_CFG2)
        cfg2_q <= wd[1:0];
      // Unmasked bits other than the change bit clear on a D status read; the change bit clears on a CI read
      dstat_q <= set_clr(dstat_q,
                 {8{rd && ra == `ISAG_OFS_DSTAT}} & ~dmask_q &
                 ~(8'h01 << `ISAG_D_CIC) |
                 {8{rd && ra == `ISAG_OFS_CIR}} &
                 (8'h01 << `ISAG_D_CIC),
                 dch_evt_in | ({7'h00, ci_chg_stb} << `ISAG_D_CIC)); // [R15] [R17]
      dext_q <= set_clr(dext_q, {8{rd && ra == `ISAG_OFS_DEXT}},
                        dch_ext_in); // [R16]
      if (ci_chg_stb)
        ci_q <= ci_code_in;
      aux_q <= (aux_q & ~({2{wlo && wa_q == `ISAG_OFS_AUXCLR}} &
               wd[`ISAG_TOP_AUX_PIN_SEVEN:`ISAG_TOP_AUX_PIN_SIX])) | aux_fall; // [R03]
    end
  end

  // B-channel receive event generation and registers
  integer c;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      arm_q <= 2'h0;
      for (c = 0; c < 2; c = c + 1) begin
        bstat_q[c] <= 8'h00;
        bext_q[c]  <= 8'h00;
        bmask_q[c] <= `ISAG_MASK_RST;
        bhdr_q[c]  <= 8'h00;
        bral_q[c]  <= 8'h00;
        brst_q[c]  <= 4'h0;
        cnt_q[c]   <= 7'h00;
        dly_q[c]   <= 2'h0;
      end
    end else begin
      for (c = 0; c < 2; c = c + 1) begin : ch
        reg [7:0] bs;
        reg [7:0] bx;
        bs = {2'h0, bch_evt_in[c*6 +: 6]};
        bx = {bch_ext_in[c*6+2 +: 4], 2'h0, bch_ext_in[c*6 +: 2]};
        if (wlo && wa_q == `ISAG_OFS_BMASK + `ISAG_CH_STRIDE * c[0])
          bmask_q[c] <= wd; // [R09]
        if (rx_msg_done[c] || rx_frame_seen[c]) begin
          cnt_q[c] <= 7'h00;
        end else if (rx_byte_stb[c]) begin
          if (cnt_q[c] == `ISAG_POOL_BYTES - 7'h01) begin
            cnt_q[c] <= 7'h00;
            bs[`ISAG_B_RPF] = 1'b1; // [R10]
          end else begin
            cnt_q[c] <= cnt_q[c] + 7'h01;
          end
        end
        if (rx_msg_done[c])
          bs[`ISAG_B_RME] = 1'b1; // [R11]
        if (rx_frame_seen[c]) begin
          if (rx_fifo_full[c]) begin
            bx[`ISAG_BX_RFO] = 1'b1; // [R12]
            arm_q[c] <= 1'b0;
          end else begin
            arm_q[c] <= 1'b1;
            dly_q[c] <= `ISAG_RFS_DELAY;
          end
        end else if (arm_q[c] && rx_byte_stb[c]) begin
          dly_q[c] <= dly_q[c] - 2'h1;
          if (dly_q[c] == 2'h1) begin
            arm_q[c] <= 1'b0;
            bhdr_q[c] <= rx_hdr_in[c*8 +: 8]; // [R14]
            bral_q[c] <= rx_rx_address_low_one_in[c*8 +: 8];
            brst_q[c] <= rx_stat_in[c*4 +: 4];
            bx[`ISAG_BX_RFS] = cfg2_q[c]; // [R13]
          end
        end
        bstat_q[c] <= set_clr(bstat_q[c], {8{rd &&
                      ra == `ISAG_OFS_BSTAT + `ISAG_CH_STRIDE * c[0]}},
                      bs); // [R05] [R08]
        bext_q[c] <= set_clr(bext_q[c], {8{rd &&
                     ra == `ISAG_OFS_BEXT + `ISAG_CH_STRIDE * c[0]}},
                     bx); // [R08]
      end
    end
  end

  // Interrupt request from every unmasked pending source except the D change bit
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      int_n <= 1'b1;
    else
      int_n <= ~|(top & ~tmask_q); // [R01] [R05] [R07] [R18]
  end

endmodule // isag_top

// ===== isag_top_props.sv
// Assertions on the aggregator's bus and interrupt ports
`timescale 1ns/1ns
module isag_top_props (
  input wire        hclk,          // Clock
  input wire        hresetn,       // Reset
  input wire        hsel,          // Select
  input wire [31:0] haddr,         // Address
  input wire [1:0]  htrans,        // Transfer
  input wire        hwrite,        // Write
  input wire [31:0] hwdata,        // Data
  input wire        hready,        // Ready
  input wire        int_n,         // Interrupt
  input wire        aux_pin_six_pin,      // Aux six
  input wire        aux_pin_seven_pin,      // Aux seven
  input wire [1:0]  rx_msg_done,   // Msg end
  input wire [1:0]  rx_frame_seen, // Frame seen
  input wire [1:0]  rx_fifo_full,  // FIFO full
  input wire [1:0]  rx_byte_stb,   // Byte
  input wire [11:0] bch_evt_in,    // B events
  input wire [11:0] bch_ext_in,    // B ext
  input wire [7:0]  dch_evt_in,    // D events
  input wire [7:0]  dch_ext_in     // D ext
);
  wire        acc = hsel && hready && htrans[1];
  wire        evt = |{dch_evt_in, dch_ext_in, bch_evt_in, bch_ext_in,
                      rx_msg_done, rx_frame_seen, rx_byte_stb};
  logic       wph_q;
  logic [4:0] wa_q;
  logic [2:0] idle_q;
  logic [3:0] act_q;
  logic [7:0] sh_q [0:31];
  // Shadow of written registers, so masks are known
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wph_q <= 1'b0;
      wa_q <= 5'h00;
      idle_q <= 3'h0;
      act_q <= 4'h0;
      for (int i = 0; i < 32; i++) sh_q[i] <= 8'h00;
    end else begin
      wph_q <= acc && hwrite;
      wa_q <= haddr[6:2];
      if (wph_q) sh_q[wa_q] <= hwdata[7:0];
      idle_q <= acc ? 3'h0 : idle_q + {2'h0, idle_q != 3'h7};
      act_q <= (evt || wph_q || $changed(aux_pin_six_pin) || $changed(aux_pin_seven_pin))
               ? 4'h0 : act_q + {3'h0, act_q != 4'hF};
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_hold; $rose(int_n) |-> idle_q < 3'h4; endproperty
  a_hold: assert property (p_hold)
    else $error("interrupt released without bus access");
  property p_mask; &sh_q[1] |=> int_n; endproperty
  a_mask: assert property (p_mask)
    else $error("interrupt while top mask all ones");
  property p_aux_pin_six; !wph_q && !sh_q[1][6] && $fell(aux_pin_six_pin) ##1
    (!aux_pin_six_pin && !acc)[*7] |=> !int_n; endproperty
  a_aux_pin_six: assert property (p_aux_pin_six)
    else $error("aux six fall gave no interrupt");
  property p_aux_pin_seven; !wph_q && !sh_q[1][7] && $fell(aux_pin_seven_pin) ##1
    (!aux_pin_seven_pin && !acc)[*7] |=> !int_n; endproperty
  a_aux_pin_seven: assert property (p_aux_pin_seven)
    else $error("aux seven fall gave no interrupt");
  property p_rme; !wph_q && !sh_q[1][3] && !sh_q[10][7] && rx_msg_done[0]
    |-> ##2 !int_n; endproperty
  a_rme: assert property (p_rme)
    else $error("message end gave no interrupt");
  property p_rfo; !wph_q && !sh_q[1][2] && rx_frame_seen[0] &&
    rx_fifo_full[0] |-> ##2 !int_n; endproperty
  a_rfo: assert property (p_rfo)
    else $error("frame overflow gave no interrupt");
  property p_dev; !wph_q && !sh_q[1][5] &&
    |(dch_evt_in & ~sh_q[4] & 8'hFB) |-> ##2 !int_n; endproperty
  a_dev: assert property (p_dev)
    else $error("unmasked D event gave no interrupt");
  property p_cause; $fell(int_n) |-> act_q < 4'h8; endproperty
  a_cause: assert property (p_cause)
    else $error("interrupt raised without a source");
endmodule // isag_top_props
bind isag_top isag_top_props u_props (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .int_n(int_n), .aux_pin_six_pin(aux_pin_six_pin),
  .aux_pin_seven_pin(aux_pin_seven_pin), .rx_msg_done(rx_msg_done),
  .rx_frame_seen(rx_frame_seen), .rx_fifo_full(rx_fifo_full),
  .rx_byte_stb(rx_byte_stb), .bch_evt_in(bch_evt_in),
  .bch_ext_in(bch_ext_in), .dch_evt_in(dch_evt_in),
  .dch_ext_in(dch_ext_in));

// ===== isag_top_tb.sv
// Self-checking bench for the interrupt aggregator
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module isag_top_tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  wire         hsel, hwrite, hreadyout, hresp, int_n;
  wire  [31:0] haddr, hwdata, hrdata;
  wire  [1:0]  htrans;
  wire  [2:0]  hsize;
  logic [23:0] ev = 24'h0;
  logic [1:0]  rff = 2'h0;
  logic [15:0] hv = 16'hA5C3;
  logic        ax6 = 1'b1, ax7 = 1'b1;
  logic [31:0] rd;
  int          n_errors = 0, check_count = 0, cyc = 0;
  always #50 hclk = ~hclk;
  isag_host u_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata));
  isag_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rx_byte_stb(ev[22:21]),
    .rx_msg_done(ev[18:17]), .rx_frame_seen(ev[20:19]),
    .rx_fifo_full(rff), .rx_hdr_in(hv), .rx_rx_address_low_one_in(~hv),
    .rx_stat_in(hv[7:0]), .bch_evt_in(12'h000), .bch_ext_in(12'h000),
    .dch_evt_in(ev[7:0]), .dch_ext_in(ev[15:8]), .ci_chg_stb(ev[16]),
    .ci_code_in(hv[11:8]), .aux_pin_six_pin(ax6), .aux_pin_seven_pin(ax7), .int_n(int_n));
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.xfer(1'b1, {24'h0, a}, {24'h0, d}, rd);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    u_host.xfer(1'b0, {24'h0, a}, 32'h0, rd);
    `CHK(rd, {24'h0, e})
  endtask
  // One-cycle event pulse, then a quiet cycle
  task automatic pe(input logic [23:0] v);
    ev <= v;
    tick(1);
    ev <= 24'h0;
    tick(1);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc > 5000) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    tick(6);
    hresetn <= 1'b1;
    `CHK(int_n, 1'b1)
    rdc(8'h04, 8'h00);
    `CHK(hresp, 1'b0)
    wr(8'h3C, 8'hFF);
    rdc(8'h3C, 8'h00);
    pe(24'h000001);
    tick(1);
    `CHK(int_n, 1'b0)
    rdc(8'h00, 8'h20);
    rdc(8'h08, 8'h01);
    rdc(8'h00, 8'h00);
    `CHK(int_n, 1'b1)
    wr(8'h10, 8'h01);
    pe(24'h000001);
    tick(1);
    `CHK(int_n, 1'b1)
    rdc(8'h08, 8'h00);
    wr(8'h10, 8'h00);
    tick(2);
    `CHK(int_n, 1'b0)
    rdc(8'h08, 8'h01);
    pe(24'h010000);
    rdc(8'h08, 8'h04);
    rdc(8'h08, 8'h04);
    rdc(8'h14, 8'h05);
    rdc(8'h08, 8'h00);
    pe(24'h000100);
    rdc(8'h00, 8'h10);
    rdc(8'h0C, 8'h01);
    rdc(8'h00, 8'h00);
    for (int i = 0; i < 2; i++) begin
      {ax7, ax6} <= i ? 2'b01 : 2'b10;
      tick(8);
      rdc(8'h00, 8'h40 << i);
      `CHK(int_n, 1'b0)
      wr(8'h04, 8'hFF);
      tick(2);
      `CHK(int_n, 1'b1)
      wr(8'h04, 8'h00);
      tick(2);
      `CHK(int_n, 1'b0)
      {ax7, ax6} <= 2'b11;
      wr(8'h1C, 8'h40 << i);
      tick(2);
      `CHK(int_n, 1'b1)
    end
    pe(24'h020000);
    tick(1);
    `CHK(int_n, 1'b0)
    rdc(8'h20, 8'h80);
    wr(8'h28, 8'h80);
    pe(24'h020000);
    rdc(8'h00, 8'h00);
    rdc(8'h20, 8'h80);
    repeat (63) pe(24'h400000);
    rdc(8'h40, 8'h00);
    pe(24'h400000);
    rdc(8'h40, 8'h40);
    pe(24'h080000);
    repeat (2) pe(24'h200000);
    rdc(8'h24, 8'h00);
    wr(8'h18, 8'h01);
    pe(24'h080000);
    pe(24'h200000);
    rdc(8'h24, 8'h00);
    pe(24'h200000);
    hv <= 16'h0000;
    rdc(8'h24, 8'h04);
    rdc(8'h2C, 8'hC3);
    rdc(8'h30, 8'h3C);
    rdc(8'h34, 8'h03);
    rff <= 2'h1;
    pe(24'h080000);
    rff <= 2'h0;
    rdc(8'h24, 8'h08);
    finish_test();
  end
endmodule // isag_top_tb
